// *** rtl/arr_pkg.sv ***
// constants, register map and state codes of the async receiver
// assumes one 25 MHz clock and a 32-bit Avalon-MM register bus
package arr_pkg;
  // register byte offsets
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_BAUD = 5'h04;
  localparam logic [4:0] ADR_DATA = 5'h08;
  localparam logic [4:0] ADR_STAT = 5'h0c;
  localparam logic [4:0] ADR_MASK = 5'h10;
  // receive_mode_select codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DOUBLE = 2'h1;
  localparam logic [1:0] generic_autobaud_code = 2'h2;
  localparam logic [1:0] lin_autobaud_code = 2'h3;
  // field positions
  localparam int CTRL_WAIT_BREAK = 2;
  localparam int DATA_FE = 8;
  localparam int DATA_VLD = 9;
  localparam int ST_RXC = 0;
  localparam int ST_FERR = 1;
  localparam int ST_BRK = 2;
  localparam int ST_SYNC = 3;
  localparam int ST_ABD = 4;
  localparam int ST_W = 5;
  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [15:0] BAUD_RST = 16'h5161;
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;
  // sampling and auto-baud counts
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] SF_NORMAL = 5'h08;
  localparam logic [4:0] SF_DOUBLE = 5'h04;
  localparam logic [3:0] BREAK_MIN_CYC = 4'hc;
  localparam logic [2:0] SYNC_LAST_FALL = 3'h3;
  localparam logic [16:0] BAUD_MIN = 17'h00064;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_START = 3'b001,
    S_DATA = 3'b010,
    S_STOP = 3'b011,
    S_BRK = 3'b100,
    S_SYNW = 3'b101,
    S_SYNM = 3'b110,
    S_SYNE = 3'b111
  } arr_state_t;
endpackage

// *** rtl/arr_rx_recovery.sv ***
// async receiver: clock/data recovery, stop check, auto-baud, regs
// assumes rx_pin is asynchronous; Avalon-MM slave on clk
//
// What this block does
// [R1] Sample each bit 16 times per bit normally, 8 times in double speed.
// [R2] Decide every data bit by majority of its three centre samples.
// [R3] Vote samples are 8,9,10 normally and 4,5,6 in double speed.
// [R4] Check only the first stop bit; further stop bits are ignored.
// [R5] A stop bit voted low sets the frame error flag.
// [R6] Normal speed: next start may begin right after the stop vote samples.
// [R7] Double speed: next start low no earlier than first sample after vote.
// [R8] Mode code 1 selects double speed with 8 samples per bit.
// [R9] The far transmitter keeps its baud error within the recommended limits.
// [R10] Auto-baud modes detect a break after 12 or more low cycles.
// [R11] Sync start bit starts a clock counter for eight bits; it becomes divisor.
// [R12] Generic mode with wait-for-break accepts a break of any length.
// [R13] Generic mode updates divisor only for counts 0x0064 to 0xffff.
// [R14] LIN mode ignores wait-for-break; break needs 12 low clock cycles.
// [R15] LIN mode checks sync is 0x55; mismatch flags error, divisor unchanged.
// [R16] Start bit accepted only if two of three vote samples read low.
// [R17] Frame error is reported together with the byte it belongs to.
`timescale 1ns/100ps
`default_nettype none
module arr_rx_recovery
  import arr_pkg::*;
#(
  parameter int DATA_BITS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_pin,
  output logic irq
);
  if (DATA_BITS < 5 || DATA_BITS > 8) begin : g_chk
    $error("DATA_BITS must lie in 5..8");
  end

  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] be);
    merge = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[8*i+:8] = new_w[8*i+:8];
      end
    end
  endfunction

  arr_state_t st_q, st_d;
  logic rx_meta_q, rx_q, rx_prev_q;
  logic [1:0] mode_q;
  logic wait_brk_q;
  logic [15:0] baud_q;
  logic [ST_W-1:0] mask_q, status_q;
  logic [7:0] rxdata_q, sh_q, sh_d;
  logic rxfe_q, rxvld_q;
  logic [31:0] rdata_q;
  logic wait_q, irq_q;
  logic [16:0] acc_q;
  logic [4:0] pos_q;
  logic [1:0] v_q;
  logic [2:0] bit_q, bit_d;
  logic [3:0] low_q;
  logic [16:0] meas_q;
  logic [15:0] intv_q, ref_q;
  logic [2:0] nfall_q;
  logic mism_q;

  // two-stage synchroniser, edge detect on the second stage only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_meta_q <= 1'b1;
      rx_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_q <= rx_meta_q;
      rx_prev_q <= rx_q;
    end
  end
  wire fall = rx_prev_q & ~rx_q;

  // mode decode
  // [R8] code 1 is double speed
  wire dbl = mode_q == MODE_DOUBLE;
  wire gen = mode_q == generic_autobaud_code;
  wire lin = mode_q == lin_autobaud_code;
  wire abd = gen | lin;
  // [R1] samples per bit
  wire [4:0] spb = dbl ? SPB_DOUBLE : SPB_NORMAL;
  // [R3] first vote sample
  wire [4:0] sf = dbl ? SF_DOUBLE : SF_NORMAL;

  // [R8] fixed step per clock, so double speed halves the bit time
  wire [16:0] acc_sum = acc_q + {9'h000, SPB_NORMAL, 3'h0};
  wire tick = acc_sum >= {1'b0, baud_q};
  wire [16:0] acc_rem = acc_sum - {1'b0, baud_q};
  wire [16:0] acc_d = !tick ? acc_sum : (acc_rem >= {1'b0, baud_q} ? 17'h00000 : acc_rem);

  // sample position 1..S within the current bit
  wire [4:0] pos_nx = (pos_q == spb) ? 5'h01 : pos_q + 5'h01;
  wire [4:0] pos_d = (st_q == S_IDLE) ? 5'h01 : (tick ? pos_nx : pos_q);
  wire in_frame = st_q == S_START || st_q == S_DATA || st_q == S_STOP;
  wire samp_a = tick && in_frame && pos_nx == sf;
  wire samp_b = tick && in_frame && pos_nx == sf + 5'h01;
  // [R3] third vote sample decides
  wire vote_now = tick && in_frame && pos_nx == sf + 5'h02;
  // [R2] majority of three centre samples
  wire maj = (v_q[0] & v_q[1]) | (v_q[0] & rx_q) | (v_q[1] & rx_q);

  // [R10] [R14] break: whole frame low and at least 12 low clocks
  wire brk_cond = abd && !maj && sh_q == 8'h00 && low_q >= BREAK_MIN_CYC;
  // [R12] [R14] wait-for-break takes any low edge as a break, generic only
  wire wait_brk = st_q == S_IDLE && gen && wait_brk_q && fall;
  // [R4] only the first stop bit is voted
  wire stop_vote = st_q == S_STOP && vote_now;
  wire frame_done = stop_vote && !brk_cond;
  wire brk_ev = (stop_vote && brk_cond) || wait_brk;

  // sync field measurement
  wire [16:0] meas_end = meas_q + 17'h00001;
  wire [15:0] intv_diff = (intv_q > ref_q) ? intv_q - ref_q : ref_q - intv_q;
  wire intv_bad = nfall_q != 3'h0 && intv_diff > {2'h0, ref_q[15:2]};
  wire mism_all = mism_q | intv_bad;
  // [R11] fifth falling edge ends eight bit times
  wire sync_done = st_q == S_SYNM && fall && nfall_q == SYNC_LAST_FALL;
  wire timeout = st_q == S_SYNM && meas_q[16];
  // [R13] valid range 0x0064..0xffff
  wire in_range = !meas_end[16] && meas_end >= BAUD_MIN;
  // [R15] 0x55 shape check in LIN mode
  wire upd_ok = sync_done && in_range && !(lin && mism_all);
  wire sync_err_ev = lin && ((sync_done && mism_all) || timeout);

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    case (st_q)
      S_IDLE: begin
        if (wait_brk) begin
          st_d = S_BRK;
        end else if (tick && !rx_q) begin
          st_d = S_START;
        end
      end
      S_START: begin
        // [R16] two of three low accepts start
        if (vote_now) begin
          st_d = maj ? S_IDLE : S_DATA;
          bit_d = 3'h0;
          sh_d = 8'h00;
        end
      end
      S_DATA: begin
        if (vote_now) begin
          sh_d = sh_q >> 1;
          sh_d[DATA_BITS-1] = maj;
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'(DATA_BITS - 1)) begin
            st_d = S_STOP;
          end
        end
      end
      S_STOP: begin
        // [R6] [R7] back to idle, or to S_BRK on a break, right after the last vote sample
        if (vote_now) begin
          st_d = brk_cond ? S_BRK : S_IDLE;
        end
      end
      S_BRK: begin
        if (rx_q) begin
          st_d = S_SYNW;
        end
      end
      S_SYNW: begin
        if (fall) begin
          st_d = S_SYNM;
        end
      end
      S_SYNM: begin
        if (sync_done || timeout) begin
          st_d = S_SYNE;
        end
      end
      S_SYNE: begin
        if (rx_q) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= S_IDLE;
      acc_q <= 17'h00000;
      pos_q <= 5'h01;
      v_q <= 2'h3;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      low_q <= 4'h0;
    end else begin
      st_q <= st_d;
      acc_q <= acc_d;
      pos_q <= pos_d;
      v_q <= {samp_b ? rx_q : v_q[1], samp_a ? rx_q : v_q[0]};
      bit_q <= bit_d;
      sh_q <= sh_d;
      low_q <= rx_q ? 4'h0 : (low_q == 4'hf ? low_q : low_q + 4'h1);
    end
  end

  // [R11] counter runs at clock rate from the sync start bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meas_q <= 17'h00000;
      intv_q <= 16'h0000;
      ref_q <= 16'h0000;
      nfall_q <= 3'h0;
      mism_q <= 1'b0;
    end else if (st_q != S_SYNM) begin
      meas_q <= 17'h00000;
      intv_q <= 16'h0000;
      nfall_q <= 3'h0;
      mism_q <= 1'b0;
    end else begin
      meas_q <= meas_end;
      intv_q <= fall ? 16'h0000 : intv_q + 16'h0001;
      if (fall) begin
        nfall_q <= nfall_q + 3'h1;
        ref_q <= (nfall_q == 3'h0) ? intv_q : ref_q;
        mism_q <= mism_all;
      end
    end
  end

  // register bus: one answer cycle per request
  wire req = (avs_read | avs_write) & wait_q;
  wire wr_en = req & avs_write;
  wire rd_en = req & avs_read;
  wire [4:0] adr = {avs_address[4:2], 2'h0};
  wire sel_ctrl = adr == ADR_CTRL;
  wire sel_baud = adr == ADR_BAUD;
  wire sel_data = adr == ADR_DATA;
  wire sel_stat = adr == ADR_STAT;
  wire sel_mask = adr == ADR_MASK;
  logic [31:0] ctrl_rd, data_rd, rd_mux;
  always_comb begin
    ctrl_rd = 32'h00000000;
    ctrl_rd[1:0] = mode_q;
    ctrl_rd[CTRL_WAIT_BREAK] = wait_brk_q;
    data_rd = 32'h00000000;
    data_rd[7:0] = rxdata_q;
    data_rd[DATA_FE] = rxfe_q;
    data_rd[DATA_VLD] = rxvld_q;
  end
  assign rd_mux = sel_ctrl ? ctrl_rd : sel_baud ? {16'h0000, baud_q} : sel_data ? data_rd
                : sel_stat ? {27'h0000000, status_q} : sel_mask ? {27'h0000000, mask_q}
                : 32'h00000000;
  wire [31:0] ctrl_w = merge(ctrl_rd, avs_writedata, avs_byteenable);
  wire [31:0] baud_w = merge({16'h0000, baud_q}, avs_writedata, avs_byteenable);
  wire [31:0] mask_w = merge({27'h0000000, mask_q}, avs_writedata, avs_byteenable);

  logic [ST_W-1:0] st_set;
  always_comb begin
    st_set = '0;
    st_set[ST_RXC] = frame_done;
    st_set[ST_FERR] = frame_done & ~maj;
    st_set[ST_BRK] = brk_ev;
    st_set[ST_SYNC] = sync_err_ev;
    st_set[ST_ABD] = upd_ok;
  end
  // read clears, a new event in the same cycle wins
  wire [ST_W-1:0] status_d = (rd_en && sel_stat ? '0 : status_q) | st_set;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_q <= MODE_RST;
      wait_brk_q <= 1'b0;
      baud_q <= BAUD_RST;
      mask_q <= MASK_RST;
      status_q <= '0;
      rdata_q <= 32'h00000000;
      wait_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      wait_q <= !req;
      rdata_q <= rd_en ? rd_mux : 32'h00000000;
      status_q <= status_d;
      irq_q <= |(status_q & mask_q);
      if (wr_en && sel_ctrl) begin
        mode_q <= ctrl_w[1:0];
      end
      if (wait_brk) begin
        wait_brk_q <= 1'b0;
      end else if (wr_en && sel_ctrl) begin
        wait_brk_q <= ctrl_w[CTRL_WAIT_BREAK];
      end
      if (wr_en && sel_mask) begin
        mask_q <= mask_w[ST_W-1:0];
      end
      // [R13] [R15] sync sets the divisor only when valid, ahead of a bus write
      if (upd_ok) begin
        baud_q <= meas_end[15:0];
      end else if (wr_en && sel_baud) begin
        baud_q <= baud_w[15:0];
      end
    end
  end

  // received byte with its own frame error; read clears valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rxdata_q <= 8'h00;
      rxfe_q <= 1'b0;
      rxvld_q <= 1'b0;
    end else if (frame_done) begin
      // [R5] [R17] error stored beside its byte
      rxdata_q <= sh_q;
      rxfe_q <= ~maj;
      rxvld_q <= 1'b1;
    end else if (rd_en && sel_data) begin
      rxvld_q <= 1'b0;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq = irq_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_start_reject: assert property (st_q == S_START && vote_now && maj |=> st_q == S_IDLE) // [R16]
    else $error("start not rejected");
  a_start_accept: assert property (st_q == S_START && vote_now && !maj |=> st_q == S_DATA) // [R16]
    else $error("start not accepted");
  a_vote_place: assert property (vote_now |-> pos_nx == (dbl ? 5'h06 : 5'h0a)) // [R3]
    else $error("vote at wrong sample");
  a_pos_bound: assert property (in_frame |-> pos_q >= 5'h01 && pos_q <= (dbl ? 5'h08 : 5'h10)) // [R1]
    else $error("sample position out of range");
  a_stop_idle: assert property (frame_done |=> st_q == S_IDLE) // [R6]
    else $error("not idle after stop vote");
  a_frame_error: assert property (frame_done |=> rxvld_q && rxfe_q == !$past(maj)) // [R5]
    else $error("frame error not with byte");
  a_gen_range: assert property (sync_done && !in_range && !(wr_en && sel_baud) |=> $stable(baud_q)) // [R13]
    else $error("divisor changed out of range");
  a_lin_sync: assert property (sync_done && lin && mism_all && !(wr_en && sel_baud)
    |=> status_q[ST_SYNC] && $stable(baud_q)) // [R15]
    else $error("sync mismatch not handled");
  a_wait_any: assert property (wait_brk |=> st_q == S_BRK && !wait_brk_q) // [R12]
    else $error("wait-for-break missed");
  a_lin_break: assert property (st_q == S_STOP && st_d == S_BRK |-> low_q >= 4'hc) // [R14]
    else $error("break shorter than 12 cycles");
  a_irq_level: assert property (##1 irq_q == |($past(status_q) & $past(mask_q)))
    else $error("irq not following status");

  c_frame: cover property (frame_done && maj);
  c_reject: cover property (st_q == S_START && vote_now && maj);
  c_update: cover property (upd_ok);
  c_sync_err: cover property (sync_err_ev);
endmodule
`default_nettype wire

// *** bench/arr_far_tx.sv ***
// far-end serial transmitter model driving the receive line
// assumes the bench calls its tasks right after a rising clk edge
`timescale 1ns/100ps
`default_nettype none
module arr_far_tx (
  input wire logic clk,
  output logic line
);
  initial line = 1'b1;

  // line held at one level for n clocks
  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clk);
  endtask

  // exact bit time, no rate error
  task automatic send(input logic [7:0] d, input int bt, input logic sv, input int sl,
                      input int idl);
    hold(1'b0, bt);
    for (int i = 0; i < 8; i++) begin
      hold(d[i], bt);
    end
    hold(sv, sl);
    if (idl > 0) begin
      hold(1'b1, idl);
    end
  endtask
endmodule
`default_nettype wire

// *** bench/async_rx_recovery_autobaud_tb.sv ***
// self-checking bench for the async receiver and its auto-baud
// assumes arr_pkg and arr_rx_recovery compiled first; 25 MHz clk
`timescale 1ns/100ps
`default_nettype none
module async_rx_recovery_autobaud_tb;
  import arr_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  wire logic rx_line;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] rd;

  always #20 clk = ~clk;

  arr_rx_recovery i_dut (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_pin(rx_line), .irq(irq)
  );
  arr_far_tx i_tx (.clk(clk), .line(rx_line));

  task automatic stop_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  // one bus cycle; held until waitrequest sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    check({31'h0, avs_waitrequest}, 32'h1, "wait back high");
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string what);
    bus(1'b0, a, 32'h0);
    check(rd & m, e, what);
  endtask

  task automatic baud_in(input logic [15:0] lo, input logic [15:0] hi);
    bus(1'b0, ADR_BAUD, 32'h0);
    check({31'h0, (rd[15:0] >= lo && rd[15:0] <= hi)}, 32'h1, "baud range");
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk(ADR_CTRL, 32'h7, 32'h0, "ctrl rst");
    rdchk(ADR_BAUD, 32'hffff, {16'h0, BAUD_RST}, "baud rst");
    rdchk(ADR_MASK, 32'h1f, 32'h0, "mask rst");
    rdchk(ADR_STAT, 32'h1f, 32'h0, "stat rst");
    bus(1'b1, 5'h14, 32'hffffffff);
    rdchk(5'h14, 32'hffffffff, 32'h0, "unmapped");
    bus(1'b1, ADR_BAUD, 32'h100);
    i_tx.send(8'ha5, 32, 1'b1, 64, 64);
    check({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, ADR_MASK, 32'h1f);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1, "irq on");
    rdchk(ADR_DATA, 32'h3ff, 32'h2a5, "byte");
    rdchk(ADR_STAT, 32'h1f, 32'h01, "stat rx");
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0, "irq off");
    i_tx.send(8'h3c, 32, 1'b0, 32, 64);
    rdchk(ADR_DATA, 32'h3ff, 32'h33c, "fe byte");
    rdchk(ADR_STAT, 32'h1f, 32'h03, "stat fe");
    i_tx.hold(1'b0, 6);
    i_tx.hold(1'b1, 400);
    rdchk(ADR_STAT, 32'h1f, 32'h0, "glitch stat");
    rdchk(ADR_DATA, 32'h200, 32'h0, "glitch data");
    i_tx.send(8'h81, 32, 1'b1, 24, 0);
    i_tx.send(8'h7e, 32, 1'b1, 32, 64);
    rdchk(ADR_DATA, 32'h3ff, 32'h27e, "early start");
    rdchk(ADR_STAT, 32'h1f, 32'h01, "early stat");
    bus(1'b1, ADR_CTRL, {30'h0, MODE_DOUBLE});
    i_tx.send(8'h81, 16, 1'b1, 14, 0);
    i_tx.send(8'h96, 16, 1'b1, 16, 64);
    rdchk(ADR_DATA, 32'h3ff, 32'h296, "double byte");
    rdchk(ADR_STAT, 32'h1f, 32'h01, "double stat");
    bus(1'b1, ADR_CTRL, {30'h0, generic_autobaud_code});
    i_tx.hold(1'b0, 352);
    i_tx.hold(1'b1, 64);
    i_tx.send(8'h55, 40, 1'b1, 40, 64);
    baud_in(16'h13e, 16'h142);
    rdchk(ADR_STAT, 32'h1c, 32'h14, "gen stat");
    i_tx.hold(1'b0, 440);
    i_tx.hold(1'b1, 80);
    i_tx.send(8'h55, 10, 1'b1, 10, 80);
    baud_in(16'h13e, 16'h142);
    rdchk(ADR_STAT, 32'h1c, 32'h04, "small stat");
    bus(1'b1, ADR_CTRL, 32'h6);
    i_tx.hold(1'b0, 8);
    i_tx.hold(1'b1, 80);
    i_tx.send(8'h55, 32, 1'b1, 32, 64);
    baud_in(16'h0fe, 16'h102);
    rdchk(ADR_STAT, 32'h1c, 32'h14, "wait stat");
    bus(1'b1, ADR_CTRL, 32'h7);
    i_tx.hold(1'b0, 8);
    i_tx.hold(1'b1, 200);
    rdchk(ADR_STAT, 32'h04, 32'h0, "lin short");
    i_tx.hold(1'b0, 352);
    i_tx.hold(1'b1, 64);
    i_tx.send(8'h54, 32, 1'b1, 32, 0);
    i_tx.send(8'hff, 32, 1'b1, 32, 64);
    baud_in(16'h0fe, 16'h102);
    rdchk(ADR_STAT, 32'h1c, 32'h0c, "lin bad");
    i_tx.hold(1'b0, 352);
    i_tx.hold(1'b1, 64);
    i_tx.send(8'h55, 48, 1'b1, 48, 64);
    baud_in(16'h17e, 16'h182);
    rdchk(ADR_STAT, 32'h1c, 32'h14, "lin good");
    stop_test();
  end
endmodule
`default_nettype wire
